// *** rtl/lpr_pkg.sv ***
// Constants and types for the LIN physical layer register bank
package lpr_pkg;

  // Register indices (word offsets in the module space)
  localparam logic [2:0] LPR_IDX_PORT_DATA = 3'h0;
  localparam logic [2:0] LPR_IDX_CONTROL   = 3'h1;
  localparam logic [2:0] LPR_IDX_TEST_A    = 3'h2;
  localparam logic [2:0] LPR_IDX_SLEW      = 3'h3;
  localparam logic [2:0] LPR_IDX_TEST_B    = 3'h4;
  localparam logic [2:0] LPR_IDX_STATUS    = 3'h5;
  localparam logic [2:0] LPR_IDX_IRQ_EN    = 3'h6;
  localparam logic [2:0] LPR_IDX_IRQ_FLAGS = 3'h7;
  localparam int         LPR_NUM_REGS      = 8;

  // Word address layout: index sits above the byte lane bits
  localparam int LPR_IDX_LSB   = 2;
  localparam int LPR_IDX_MSB   = 4;
  localparam int LPR_BASE_LSB  = 5;

  // Field positions
  localparam int LPR_TX_DRIVE_BIT  = 1;
  localparam int LPR_RX_STATE_BIT  = 0;
  localparam int LPR_ENABLE_BIT    = 3;
  localparam int LPR_RECEIVE_ONLY_SELECT_BIT    = 2;
  localparam int LPR_WAKEUP_BIT    = 1;
  localparam int LPR_PULLUP_BIT    = 0;
  localparam int LPR_DT_DIS_BIT    = 7;
  localparam int LPR_SLOPE_MSB     = 1;
  localparam int LPR_SLOPE_LSB     = 0;
  localparam int LPR_DT_STATUS_BIT = 7;
  localparam int LPR_DT_IRQ_BIT    = 7;
  localparam int LPR_OC_IRQ_BIT    = 6;

  // Writable masks per register
  localparam logic [7:0] LPR_MASK_PORT_DATA = 8'h02;
  localparam logic [7:0] LPR_MASK_CONTROL   = 8'h0f;
  localparam logic [7:0] LPR_MASK_TEST      = 8'hff;
  localparam logic [7:0] LPR_MASK_SLEW      = 8'h83;
  localparam logic [7:0] LPR_MASK_IRQ       = 8'hc0;

  // Reset value and reserved slope code
  localparam logic [7:0] LPR_RST_BYTE       = 8'h00;
  localparam logic [1:0] LPR_SLOPE_RESERVED = 2'h3;

  // Power modes presented to the analog front end
  typedef enum logic [1:0] {
    LPR_MODE_SHUTDOWN = 2'b00,
    LPR_MODE_NORMAL   = 2'b01,
    LPR_MODE_RECEIVE_ONLY_SELECT   = 2'b10,
    LPR_MODE_STANDBY  = 2'b11
  } lpr_mode_e;

  // APB access phases
  typedef enum logic [1:0] {
    LPR_APB_IDLE   = 2'b00,
    LPR_APB_ACCESS = 2'b01,
    LPR_APB_DONE   = 2'b10
  } lpr_apb_e;

endpackage

// *** rtl/lpr_apb_slave.sv ***
// APB slave front end: decodes base and index, answers after two wait states
`timescale 1ns/1ns
module lpr_apb_slave
  import lpr_pkg::*;
#(
  parameter logic [31:0] BASE_ADDR = 32'h0000_0000
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic             pslverr,
  // Register side
  output logic             wr_stb,
  output logic [2:0]       wr_idx,
  output logic [7:0]       wr_data,
  output logic [2:0]       rd_idx
);

  lpr_apb_e   state_reg, state_next;
  logic       hit;
  logic       wr_next;

  // Module space is one aligned block of eight words
  assign hit     = (paddr[31:LPR_BASE_LSB] == BASE_ADDR[31:LPR_BASE_LSB])
                   && (paddr[LPR_IDX_LSB-1:0] == 2'h0); // R10
  assign rd_idx  = paddr[LPR_IDX_MSB:LPR_IDX_LSB];
  assign wr_idx  = paddr[LPR_IDX_MSB:LPR_IDX_LSB];
  assign wr_data = pwdata[7:0];

  always_comb begin
    state_next = state_reg;
    wr_next    = 1'b0;
    unique case (state_reg)
      LPR_APB_IDLE: begin
        if (psel && penable) begin
          state_next = LPR_APB_ACCESS;
        end
      end
      LPR_APB_ACCESS: begin
        state_next = LPR_APB_DONE;
        wr_next    = pwrite && hit && pstrb[0];
      end
      LPR_APB_DONE: begin
        state_next = LPR_APB_IDLE;
      end
      default: begin
        state_next = LPR_APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= LPR_APB_IDLE;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      wr_stb    <= 1'b0;
    end else begin
      state_reg <= state_next;
      pready    <= (state_reg == LPR_APB_ACCESS);
      pslverr   <= (state_reg == LPR_APB_ACCESS) && !hit;
      wr_stb    <= wr_next;
    end
  end

endmodule

// *** rtl/lpr_mode_ctrl.sv ***
// Derives the front-end mode and pullup selection from control bits
`timescale 1ns/1ns
module lpr_mode_ctrl
  import lpr_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Control bits
  input  wire logic phy_enable,
  input  wire logic receive_only_select,
  input  wire logic standby_wakeup_enable,
  input  wire logic strong_pullup_select,
  input  wire logic standby_req,
  // Front-end controls
  output lpr_mode_e mode,
  output logic      strong_pullup_on,
  output logic      wakeup_active,
  output logic      transmitter_on
);

  lpr_mode_e mode_next;
  logic      pullup_next;

  always_comb begin
    if (!phy_enable) begin
      mode_next = LPR_MODE_SHUTDOWN; // R3
    end else if (standby_req) begin
      mode_next = LPR_MODE_STANDBY;
    end else if (receive_only_select) begin
      mode_next = LPR_MODE_RECEIVE_ONLY_SELECT; // R5
    end else begin
      mode_next = LPR_MODE_NORMAL;
    end
    // Strong pullup barred in shutdown and in standby without wake-up
    pullup_next = strong_pullup_select && phy_enable
                  && !(standby_req && !standby_wakeup_enable); // R7 R8
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode             <= LPR_MODE_SHUTDOWN;
      strong_pullup_on <= 1'b0;
      wakeup_active    <= 1'b0;
      transmitter_on   <= 1'b0;
    end else begin
      mode             <= mode_next;
      strong_pullup_on <= pullup_next;
      wakeup_active    <= (mode_next == LPR_MODE_STANDBY) && standby_wakeup_enable; // R6
      transmitter_on   <= (mode_next == LPR_MODE_NORMAL); // R3 R5
    end
  end

endmodule

// *** rtl/lpr_reg_bank.sv ***
// Register bank of the LIN physical layer transceiver
`timescale 1ns/1ns
// Contract
// R1 - Port data bit 1 drives the transmit input when routing selects it.
// R2 - Port data bit 0 reads the receive output; writes ignored.
// R3 - Enable low means shutdown: all functions off, only weak pullup.
// R4 - All registers stay accessible in shutdown.
// R5 - Control bit 2 selects receive-only mode.
// R6 - Control bit 1 enables wake-up detection during standby.
// R7 - Pullup select low connects only the weak pullup.
// R8 - Strong pullup only when enabled and not standby without wake-up.
// R9 - Factory test registers accept writes only in special chip mode.
// R10 - Registers decode at module base plus offset.
// R11 - Port data register accessible at any time.
// R12 - Timeout disable and slope bits writable only with enable low; 11 reserved.
// R13 - Interrupt flags clear on writing one; zero leaves them.
// R14 - Status register read-only; top bit shows transmit still dominant.
// R15 - Unimplemented bits read zero and ignore writes.
module lpr_reg_bank
  import lpr_pkg::*;
#(
  parameter logic [31:0] BASE_ADDR = 32'h0000_0000
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  input  wire logic [2:0]  pprot,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Chip-level context
  input  wire logic        special_mode,
  input  wire logic        standby_req,
  input  wire logic        tx_route_sel,
  input  wire logic        tx_route_other,
  // Front-end status events
  input  wire logic        phy_receive_output,
  input  wire logic        dominant_timeout_event,
  input  wire logic        dominant_timeout_status,
  input  wire logic        overcurrent_event,
  // Front-end controls
  output logic             phy_transmit_input,
  output lpr_mode_e        phy_mode,
  output logic             strong_pullup_on,
  output logic             wakeup_active,
  output logic             transmitter_on,
  output logic             dominant_timeout_disable,
  output logic [1:0]       slope_select,
  output logic [7:0]       factory_test_a,
  output logic [7:0]       factory_test_b,
  output logic             irq_dominant_timeout,
  output logic             irq_overcurrent
);

  logic        wr_stb;
  logic [2:0]  wr_idx;
  logic [7:0]  wr_data;
  logic [2:0]  rd_idx;
  logic        ready_int;
  logic        err_int;

  logic [7:0]  port_data_reg,   port_data_next;
  logic [7:0]  control_reg,     control_next;
  logic [7:0]  test_a_reg,      test_a_next;
  logic [7:0]  slew_reg,        slew_next;
  logic [7:0]  test_b_reg,      test_b_next;
  logic [7:0]  irq_en_reg,      irq_en_next;
  logic [7:0]  irq_flags_reg,   irq_flags_next;
  logic [7:0]  rd_byte;
  logic [7:0]  set_flags;
  logic [7:0]  clr_flags;
  logic [31:0] prdata_next;

  lpr_apb_slave #(
    .BASE_ADDR (BASE_ADDR)
  ) u_apb (
    .ref_clk (ref_clk),
    .reset   (reset),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pstrb   (pstrb),
    .pready  (ready_int),
    .pslverr (err_int),
    .wr_stb  (wr_stb),
    .wr_idx  (wr_idx),
    .wr_data (wr_data),
    .rd_idx  (rd_idx)
  );

  assign pready  = ready_int;
  assign pslverr = err_int;

  lpr_mode_ctrl u_mode (
    .ref_clk               (ref_clk),
    .reset                 (reset),
    .phy_enable            (control_reg[LPR_ENABLE_BIT]),
    .receive_only_select   (control_reg[LPR_RECEIVE_ONLY_SELECT_BIT]),
    .standby_wakeup_enable (control_reg[LPR_WAKEUP_BIT]),
    .strong_pullup_select  (control_reg[LPR_PULLUP_BIT]),
    .standby_req           (standby_req),
    .mode                  (phy_mode),
    .strong_pullup_on      (strong_pullup_on),
    .wakeup_active         (wakeup_active),
    .transmitter_on        (transmitter_on)
  );

  // Hardware flag events, one bit per source
  always_comb begin
    set_flags                 = LPR_RST_BYTE;
    set_flags[LPR_DT_IRQ_BIT] = dominant_timeout_event;
    set_flags[LPR_OC_IRQ_BIT] = overcurrent_event;
  end

  // Register write logic; no mode gating on accessibility in shutdown
  always_comb begin
    port_data_next = port_data_reg;
    control_next   = control_reg;
    test_a_next    = test_a_reg;
    slew_next      = slew_reg;
    test_b_next    = test_b_reg;
    irq_en_next    = irq_en_reg;
    clr_flags      = LPR_RST_BYTE;
    if (wr_stb) begin // R4
      unique case (wr_idx)
        LPR_IDX_PORT_DATA: begin
          port_data_next = wr_data & LPR_MASK_PORT_DATA; // R2 R11 R15
        end
        LPR_IDX_CONTROL: begin
          control_next = wr_data & LPR_MASK_CONTROL; // R15
        end
        LPR_IDX_TEST_A: begin
          if (special_mode) begin
            test_a_next = wr_data & LPR_MASK_TEST; // R9
          end
        end
        LPR_IDX_SLEW: begin
          // Reserved slope code is refused so the slope never enters it
          if (!control_reg[LPR_ENABLE_BIT]
              && (wr_data[LPR_SLOPE_MSB:LPR_SLOPE_LSB] != LPR_SLOPE_RESERVED)) begin
            slew_next = wr_data & LPR_MASK_SLEW; // R12
          end
        end
        LPR_IDX_TEST_B: begin
          if (special_mode) begin
            test_b_next = wr_data & LPR_MASK_TEST; // R9
          end
        end
        LPR_IDX_STATUS: begin
          port_data_next = port_data_reg; // R14
        end
        LPR_IDX_IRQ_EN: begin
          irq_en_next = wr_data & LPR_MASK_IRQ; // R15
        end
        LPR_IDX_IRQ_FLAGS: begin
          clr_flags = wr_data & LPR_MASK_IRQ; // R13
        end
      endcase
    end
    // A new event in the clearing cycle survives the clear
    irq_flags_next = ((irq_flags_reg & ~clr_flags) | set_flags) & LPR_MASK_IRQ; // R13
  end

  // Read mux; unimplemented bits are zero
  always_comb begin
    rd_byte = LPR_RST_BYTE;
    unique case (rd_idx)
      LPR_IDX_PORT_DATA: begin
        rd_byte                   = port_data_reg;
        rd_byte[LPR_RX_STATE_BIT] = phy_receive_output; // R2
      end
      LPR_IDX_CONTROL:   rd_byte = control_reg;
      LPR_IDX_TEST_A:    rd_byte = test_a_reg;
      LPR_IDX_SLEW:      rd_byte = slew_reg;
      LPR_IDX_TEST_B:    rd_byte = test_b_reg;
      LPR_IDX_STATUS: begin
        rd_byte[LPR_DT_STATUS_BIT] = dominant_timeout_status; // R14
      end
      LPR_IDX_IRQ_EN:    rd_byte = irq_en_reg;
      LPR_IDX_IRQ_FLAGS: rd_byte = irq_flags_reg;
    endcase
    prdata_next = {24'h00_0000, rd_byte}; // R15
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      port_data_reg <= LPR_RST_BYTE;
      control_reg   <= LPR_RST_BYTE;
      test_a_reg    <= LPR_RST_BYTE;
      slew_reg      <= LPR_RST_BYTE;
      test_b_reg    <= LPR_RST_BYTE;
      irq_en_reg    <= LPR_RST_BYTE;
      irq_flags_reg <= LPR_RST_BYTE;
      prdata        <= 32'h0000_0000;
    end else begin
      port_data_reg <= port_data_next;
      control_reg   <= control_next;
      test_a_reg    <= test_a_next;
      slew_reg      <= slew_next;
      test_b_reg    <= test_b_next;
      irq_en_reg    <= irq_en_next;
      irq_flags_reg <= irq_flags_next;
      prdata        <= prdata_next;
    end
  end

  // Front-end outputs, registered
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phy_transmit_input       <= 1'b1;
      dominant_timeout_disable <= 1'b0;
      slope_select             <= 2'h0;
      factory_test_a           <= LPR_RST_BYTE;
      factory_test_b           <= LPR_RST_BYTE;
      irq_dominant_timeout     <= 1'b0;
      irq_overcurrent          <= 1'b0;
    end else begin
      // Follows tx_route_other when routing picks another source
      phy_transmit_input       <= tx_route_sel ? port_data_next[LPR_TX_DRIVE_BIT]
                                               : tx_route_other; // R1
      dominant_timeout_disable <= slew_next[LPR_DT_DIS_BIT];
      slope_select             <= slew_next[LPR_SLOPE_MSB:LPR_SLOPE_LSB];
      factory_test_a           <= test_a_next;
      factory_test_b           <= test_b_next;
      irq_dominant_timeout     <= irq_flags_next[LPR_DT_IRQ_BIT] & irq_en_next[LPR_DT_IRQ_BIT];
      irq_overcurrent          <= irq_flags_next[LPR_OC_IRQ_BIT] & irq_en_next[LPR_OC_IRQ_BIT];
    end
  end

endmodule

// *** test/lpr_reg_bank_properties.sv ***
// Port-level checks of the register bank
`timescale 1ns/1ns
module lpr_reg_bank_chk
  import lpr_pkg::*;
#(
  parameter logic [31:0] BASE_ADDR = 32'h0000_0000
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        reset,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Transmit routing and front end
  input wire logic        tx_route_sel,
  input wire logic        tx_route_other,
  input wire logic        phy_transmit_input,
  input wire lpr_mode_e   phy_mode,
  input wire logic        strong_pullup_on,
  input wire logic        wakeup_active,
  input wire logic        transmitter_on
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  ready_timing_a: assert property (psel && $rose(penable) |-> ##1 !pready ##1 pready)
    else $error("pready not two edges after access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  addr_miss_a: assert property (pready |-> pslverr ==
    (paddr[31:5] != BASE_ADDR[31:5] || paddr[1:0] != 2'h0))
    else $error("pslverr does not match address decode");
  // Guarded on the first edge out of reset, where the output still shows its reset level
  tx_other_a: assert property (!$past(reset) && !$past(tx_route_sel) |->
    phy_transmit_input == $past(tx_route_other))
    else $error("transmit input not from alternate source");
  rdata_high_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  shutdown_off_a: assert property (phy_mode == LPR_MODE_SHUTDOWN |->
    !transmitter_on && !wakeup_active && !strong_pullup_on)
    else $error("function active in shutdown");
  receive_only_select_tx_a: assert property (phy_mode == LPR_MODE_RECEIVE_ONLY_SELECT |-> !transmitter_on)
    else $error("transmitter on in receive-only");
  pullup_gate_a: assert property (strong_pullup_on |-> phy_mode != LPR_MODE_SHUTDOWN &&
    (phy_mode != LPR_MODE_STANDBY || wakeup_active))
    else $error("strong pullup where barred");
  wake_standby_a: assert property (wakeup_active |-> phy_mode == LPR_MODE_STANDBY)
    else $error("wake-up active outside standby");
endmodule

bind lpr_reg_bank lpr_reg_bank_chk #(.BASE_ADDR(BASE_ADDR)) i_chk (.ref_clk, .reset, .psel,
  .penable, .paddr, .prdata, .pready, .pslverr, .tx_route_sel, .tx_route_other,
  .phy_transmit_input, .phy_mode, .strong_pullup_on, .wakeup_active, .transmitter_on);

// *** test/tb.sv ***
// Self-checking bench for the register bank
`timescale 1ns/1ns
module tb;
  import lpr_pkg::*;
  localparam logic [31:0] B = 32'h0000_0100;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic        special_mode = 1'b0;
  logic        standby_req = 1'b0;
  logic        tx_route_sel = 1'b0;
  logic        tx_route_other = 1'b1;
  logic        phy_receive_output = 1'b0;
  logic        dominant_timeout_event = 1'b0;
  logic        dominant_timeout_status = 1'b0;
  logic        overcurrent_event = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        phy_transmit_input;
  lpr_mode_e   phy_mode;
  logic        strong_pullup_on;
  logic        wakeup_active;
  logic        transmitter_on;
  logic        dominant_timeout_disable;
  logic [1:0]  slope_select;
  logic [7:0]  factory_test_a;
  logic [7:0]  factory_test_b;
  logic        irq_dominant_timeout;
  logic        irq_overcurrent;
  logic [31:0] rdat;
  logic        err;
  int          fails = 0;
  int          checked = 0;

  lpr_reg_bank #(.BASE_ADDR(B)) i_dut (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb(4'hf), .pprot(3'h0), .prdata, .pready, .pslverr, .special_mode,
    .standby_req, .tx_route_sel, .tx_route_other, .phy_receive_output,
    .dominant_timeout_event, .dominant_timeout_status, .overcurrent_event,
    .phy_transmit_input, .phy_mode, .strong_pullup_on, .wakeup_active, .transmitter_on,
    .dominant_timeout_disable, .slope_select, .factory_test_a, .factory_test_b,
    .irq_dominant_timeout, .irq_overcurrent);

  always #25 ref_clk = ~ref_clk;

  function automatic logic [31:0] x1(input logic v);
    return {31'h0, v};
  endfunction

  task check(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, s, x);
    end
  endtask

  task finish_test;
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Holds the request until pready is sampled high; a lost answer counts as a mismatch
  task apb(input logic w, input logic [31:0] a, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) fails++;
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [2:0] i, input logic [7:0] d);
    apb(1'b1, B + {27'h0, i, 2'h0}, d);
  endtask

  task rd(input logic [2:0] i, input logic [7:0] x);
    apb(1'b0, B + {27'h0, i, 2'h0}, 8'h00);
    check(rdat, {24'h0, x});
  endtask

  task settle;
    repeat (3) @(posedge ref_clk);
  endtask

  task mode_chk(input logic [7:0] c, input logic s, input lpr_mode_e m, input logic p,
                input logic wk);
    standby_req <= s;
    wr(LPR_IDX_CONTROL, c);
    settle;
    check({30'h0, phy_mode}, {30'h0, m});
    check(x1(strong_pullup_on), x1(p));
    check(x1(wakeup_active), x1(wk));
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < LPR_NUM_REGS; i++) rd(3'(i), 8'h00);
    check(x1(phy_transmit_input), 32'h1);
    $display("test reset done");
    tx_route_sel <= 1'b1;
    wr(LPR_IDX_PORT_DATA, 8'hff);
    rd(LPR_IDX_PORT_DATA, 8'h02);
    phy_receive_output <= 1'b1;
    rd(LPR_IDX_PORT_DATA, 8'h03);
    check(x1(phy_transmit_input), 32'h1);
    wr(LPR_IDX_PORT_DATA, 8'h01);
    settle;
    check(x1(phy_transmit_input), 32'h0);
    tx_route_sel <= 1'b0;
    settle;
    check(x1(phy_transmit_input), 32'h1);
    $display("test port data done");
    wr(LPR_IDX_SLEW, 8'hff);
    rd(LPR_IDX_SLEW, 8'h00);
    wr(LPR_IDX_SLEW, 8'h82);
    rd(LPR_IDX_SLEW, 8'h82);
    check({29'h0, dominant_timeout_disable, slope_select}, 32'h6);
    wr(LPR_IDX_CONTROL, 8'h08);
    wr(LPR_IDX_SLEW, 8'h01);
    rd(LPR_IDX_SLEW, 8'h82);
    $display("test slew done");
    mode_chk(8'h01, 1'b0, LPR_MODE_SHUTDOWN, 1'b0, 1'b0);
    mode_chk(8'h08, 1'b0, LPR_MODE_NORMAL, 1'b0, 1'b0);
    mode_chk(8'h09, 1'b0, LPR_MODE_NORMAL, 1'b1, 1'b0);
    mode_chk(8'h0d, 1'b0, LPR_MODE_RECEIVE_ONLY_SELECT, 1'b1, 1'b0);
    mode_chk(8'h0a, 1'b0, LPR_MODE_NORMAL, 1'b0, 1'b0);
    mode_chk(8'h09, 1'b1, LPR_MODE_STANDBY, 1'b0, 1'b0);
    mode_chk(8'h0b, 1'b1, LPR_MODE_STANDBY, 1'b1, 1'b1);
    standby_req <= 1'b0;
    wr(LPR_IDX_CONTROL, 8'hf0);
    rd(LPR_IDX_CONTROL, 8'h00);
    wr(LPR_IDX_PORT_DATA, 8'h02);
    rd(LPR_IDX_PORT_DATA, 8'h03);
    $display("test modes done");
    wr(LPR_IDX_TEST_A, 8'h5a);
    rd(LPR_IDX_TEST_A, 8'h00);
    special_mode <= 1'b1;
    wr(LPR_IDX_TEST_A, 8'h5a);
    wr(LPR_IDX_TEST_B, 8'ha5);
    special_mode <= 1'b0;
    rd(LPR_IDX_TEST_A, 8'h5a);
    rd(LPR_IDX_TEST_B, 8'ha5);
    check({16'h0, factory_test_a, factory_test_b}, 32'h5aa5);
    wr(LPR_IDX_STATUS, 8'hff);
    rd(LPR_IDX_STATUS, 8'h00);
    dominant_timeout_status <= 1'b1;
    rd(LPR_IDX_STATUS, 8'h80);
    $display("test test and status done");
    wr(LPR_IDX_IRQ_EN, 8'hff);
    rd(LPR_IDX_IRQ_EN, 8'hc0);
    dominant_timeout_event <= 1'b1;
    overcurrent_event <= 1'b1;
    @(posedge ref_clk);
    dominant_timeout_event <= 1'b0;
    overcurrent_event <= 1'b0;
    rd(LPR_IDX_IRQ_FLAGS, 8'hc0);
    check({30'h0, irq_dominant_timeout, irq_overcurrent}, 32'h3);
    wr(LPR_IDX_IRQ_FLAGS, 8'h80);
    rd(LPR_IDX_IRQ_FLAGS, 8'h40);
    wr(LPR_IDX_IRQ_FLAGS, 8'h00);
    rd(LPR_IDX_IRQ_FLAGS, 8'h40);
    wr(LPR_IDX_IRQ_FLAGS, 8'h40);
    rd(LPR_IDX_IRQ_FLAGS, 8'h00);
    check({30'h0, irq_dominant_timeout, irq_overcurrent}, 32'h0);
    $display("test flags done");
    apb(1'b1, B + 32'h20, 8'h00);
    check(x1(err), 32'h1);
    apb(1'b1, B + 32'h1, 8'h00);
    check(x1(err), 32'h1);
    rd(LPR_IDX_PORT_DATA, 8'h03);
    check(x1(err), 32'h0);
    $display("test decode done");
    finish_test;
  end

  // About 300 cycles of traffic; 20000 cycles, over sixty times that, is a hang
  initial begin
    #(20000 * 50);
    fails++;
    finish_test;
  end
endmodule
